// [design/actuator_motion_controller.v]
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ns
`include "actuator_map.vh"
// Notes on behaviour
// - Logic-level extend and retract inputs; both together stop
// - Sleep after fifteen idle seconds
// - New move command wakes and executes
// - Brake when a motion command drops and neither the other command nor the follower drives
// - Extend input extends, retract input retracts
// - End outputs close at min and max stroke
// - Follower tracks setpoint over 0.5-4.5 V span
// - Below span retracts fully, above extends fully
// - Linear placement, stroke over four per volt
// - Five second extend hold stores extend limit
// - Five second retract hold stores retract limit
// - Both held five seconds restores full stroke
// - Programming only at standstill, setpoint outside span
// - Motion confined within limits, span remapped
module actuator_motion_controller
#(
  parameter        POS_W            = `POS_WIDTH,
  parameter [31:0] IDLE_CYCLES      = `IDLE_CYCLES,
  parameter [31:0] PROG_HOLD_CYCLES = `PROG_HOLD_CYCLES
)
(
  input  wire             pclk,
  input  wire             presetn,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  input  wire             extend_cmd,
  input  wire             retract_cmd,
  input  wire             prog_extend,
  input  wire             prog_retract,
  input  wire [POS_W-1:0] setpoint,
  input  wire [POS_W-1:0] position,
  output reg              drive_extend,
  output reg              drive_retract,
  output reg              brake,
  output reg              sleeping,
  output reg              end_min,
  output reg              end_max
);

  localparam [POS_W-1:0] SPAN_LO  = `SPAN_LO_CODE;
  localparam [POS_W-1:0] SPAN_HI  = `SPAN_HI_CODE;
  localparam [POS_W-1:0] DEADBAND = `FOLLOW_DEADBAND;
  localparam [POS_W-1:0] MECH_MIN = `POS_MIN;
  localparam [POS_W-1:0] MECH_MAX = `POS_MAX;

  reg              follow_en;
  reg [POS_W-1:0]  extend_limit;
  reg [POS_W-1:0]  retract_limit;
  reg [POS_W-1:0]  target;
  reg              next_drive_extend;
  reg              next_drive_retract;
  reg              next_sleeping;
  reg [POS_W-1:0]  next_target;
  reg              next_brake;
  reg              next_end_min;
  reg              next_end_max;
  reg [31:0]       read_value;
  reg              addr_ok;

  wire             fire_ext;
  wire             fire_ret;
  wire             fire_both;
  wire             fire_idle;

  // Command decode; both asserted together is a stop
  wire manual_ext = extend_cmd & ~retract_cmd;
  wire manual_ret = retract_cmd & ~extend_cmd;
  wire both_cmd   = extend_cmd & retract_cmd;
  wire any_cmd    = extend_cmd | retract_cmd;
  wire any_prog   = prog_extend | prog_retract;

  // Setpoint to target, span remapped onto the programmed limits
  reg [POS_W-1:0]   sp_off;
  reg [POS_W-1:0]   range;
  reg [2*POS_W-1:0] product;
  reg [2*POS_W-1:0] quotient;

  always @*
  begin
    sp_off   = setpoint - SPAN_LO;
    range    = extend_limit - retract_limit;
    product  = sp_off * range;
    quotient = product / (SPAN_HI - SPAN_LO);
    if (setpoint <= SPAN_LO)
      next_target = retract_limit;
    else if (setpoint >= SPAN_HI)
      next_target = extend_limit;
    else
      next_target = retract_limit + quotient[POS_W-1:0];
  end

  // Divide is a long path; the follower can stand one cycle of lag
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      target <= MECH_MIN;
    else
      target <= next_target;
  end

  // Follower error beyond the deadband; the deadband stops hunting
  wire [POS_W:0] pos_wide = {1'b0, position};
  wire [POS_W:0] tgt_wide = {1'b0, target};
  wire [POS_W:0] db_wide  = {1'b0, DEADBAND};
  wire err_ext    = pos_wide + db_wide < tgt_wide;
  wire err_ret    = tgt_wide + db_wide < pos_wide;
  wire follow_ext = follow_en & ~any_cmd & err_ext;
  wire follow_ret = follow_en & ~any_cmd & err_ret;
  // Asleep, a follower error still counts, so a new setpoint is obeyed
  wire follow_err = follow_ext | follow_ret;

  // Motion stops at the programmed limits
  wire room_ext = position < extend_limit;
  wire room_ret = position > retract_limit;

  // A live command overrides sleep in the same cycle
  wire wake = any_cmd | any_prog | follow_err;

  always @*
  begin
    next_drive_extend  = 1'b0;
    next_drive_retract = 1'b0;
    next_sleeping      = sleeping;
    if (wake)
      next_sleeping = 1'b0;
    else if (fire_idle)
      next_sleeping = 1'b1;
    if (!both_cmd && !next_sleeping)
    begin
      next_drive_extend  = (manual_ext | follow_ext) & room_ext;
      next_drive_retract = (manual_ret | follow_ret) & room_ret;
    end
  end

  // Awake and not driving means braking, so a withdrawn command brakes unless the other command or the follower then drives
  always @*
  begin
    next_brake   = ~next_drive_extend & ~next_drive_retract & ~next_sleeping;
    next_end_min = (position <= MECH_MIN);
    next_end_max = (position >= MECH_MAX);
  end

  // Idle hold: nothing commanded, nothing moving, still awake
  wire idle_now = ~wake & ~drive_extend & ~drive_retract & ~sleeping;

  hold_timer #(.HOLD_CYCLES(IDLE_CYCLES)) idle_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .active  (idle_now),
    .fire    (fire_idle)
  );

  // Programming qualifies only at standstill with setpoint outside the span
  wire prog_ok   = ~drive_extend & ~drive_retract & ~any_cmd &
                   ((setpoint < SPAN_LO) | (setpoint > SPAN_HI));
  wire hold_ext  = prog_ok & prog_extend & ~prog_retract;
  wire hold_ret  = prog_ok & prog_retract & ~prog_extend;
  wire hold_both = prog_ok & prog_extend & prog_retract;

  hold_timer #(.HOLD_CYCLES(PROG_HOLD_CYCLES)) ext_prog_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .active  (hold_ext),
    .fire    (fire_ext)
  );

  hold_timer #(.HOLD_CYCLES(PROG_HOLD_CYCLES)) ret_prog_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .active  (hold_ret),
    .fire    (fire_ret)
  );

  hold_timer #(.HOLD_CYCLES(PROG_HOLD_CYCLES)) clear_prog_timer
  (
    .pclk    (pclk),
    .presetn (presetn),
    .active  (hold_both),
    .fire    (fire_both)
  );

  // Limit storage; no ordering check, an inverted pair blocks motion while position lies between the two limits
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      extend_limit  <= MECH_MAX;
      retract_limit <= MECH_MIN;
    end
    else if (fire_both)
    begin
      extend_limit  <= MECH_MAX;
      retract_limit <= MECH_MIN;
    end
    else if (fire_ext)
      extend_limit <= position;
    else if (fire_ret)
      retract_limit <= position;
  end

  // Motor outputs, all registered
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      drive_extend  <= 1'b0;
      drive_retract <= 1'b0;
      brake         <= 1'b0;
      sleeping      <= 1'b0;
      end_min       <= 1'b0;
      end_max       <= 1'b0;
    end
    else
    begin
      drive_extend  <= next_drive_extend;
      drive_retract <= next_drive_retract;
      sleeping      <= next_sleeping;
      brake         <= next_brake;
      end_min       <= next_end_min;
      end_max       <= next_end_max;
    end
  end

  // Register read decode
  always @*
  begin
    read_value = 32'h0000_0000;
    addr_ok    = 1'b1;
    if (paddr == `REG_CTRL_OFS)
      read_value[`CTRL_FOLLOW_BIT] = follow_en;
    else if (paddr == `REG_STATUS_OFS)
    begin
      read_value[`STAT_SLEEP_BIT]   = sleeping;
      read_value[`STAT_END_MIN_BIT] = end_min;
      read_value[`STAT_END_MAX_BIT] = end_max;
      read_value[`STAT_EXT_BIT]     = drive_extend;
      read_value[`STAT_RET_BIT]     = drive_retract;
      read_value[`STAT_BRAKE_BIT]   = brake;
    end
    else if (paddr == `REG_LIMITS_OFS)
    begin
      read_value[`FIELD_LO_LSB +: POS_W] = retract_limit;
      read_value[`FIELD_HI_LSB +: POS_W] = extend_limit;
    end
    else if (paddr == `REG_POSITION_OFS)
    begin
      read_value[`FIELD_LO_LSB +: POS_W] = position;
      read_value[`FIELD_HI_LSB +: POS_W] = target;
    end
    else
      addr_ok = 1'b0;
  end

  // APB slave: answer is prepared in setup so pready comes from a flop
  wire setup_phase  = psel & ~penable;
  wire access_done  = psel & penable & pready;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      prdata    <= 32'h0000_0000;
      follow_en <= 1'b0;
    end
    else
    begin
      if (setup_phase)
      begin
        pready  <= 1'b1;
        pslverr <= ~addr_ok;
        prdata  <= pwrite ? 32'h0000_0000 : read_value;
      end
      else
      begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
      end
      // Only control is writable; other offsets ignore writes
      if (access_done && pwrite && paddr == `REG_CTRL_OFS)
        follow_en <= pwdata[`CTRL_FOLLOW_BIT];
    end
  end

endmodule // actuator_motion_controller

// [design/hold_timer.v]
`timescale 1ns/1ns
// Pulses once when active has held for HOLD_CYCLES; rearms after active drops
module hold_timer
#(
  parameter [31:0] HOLD_CYCLES = 32'd100
)
(
  input  wire pclk,
  input  wire presetn,
  input  wire active,
  output reg  fire
);

  reg [31:0] count;
  reg        done;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= 32'h0000_0000;
      done  <= 1'b0;
      fire  <= 1'b0;
    end
    else if (!active)
    begin
      // Any break in the hold restarts the wait
      count <= 32'h0000_0000;
      done  <= 1'b0;
      fire  <= 1'b0;
    end
    else if (!done && count >= HOLD_CYCLES - 32'd1)
    begin
      done <= 1'b1;
      fire <= 1'b1;
    end
    else
    begin
      if (!done)
        count <= count + 32'd1;
      fire <= 1'b0;
    end
  end

endmodule // hold_timer

// [inc/actuator_map.vh]
`ifndef ACTUATOR_MAP_VH
`define ACTUATOR_MAP_VH

// Register byte offsets
`define REG_CTRL_OFS      12'h000
`define REG_STATUS_OFS    12'h004
`define REG_LIMITS_OFS    12'h008
`define REG_POSITION_OFS  12'h00C

// Control fields
`define CTRL_FOLLOW_BIT   0
`define CTRL_RESET_VALUE  32'h0000_0000

// Status fields
`define STAT_SLEEP_BIT    0
`define STAT_END_MIN_BIT  1
`define STAT_END_MAX_BIT  2
`define STAT_EXT_BIT      3
`define STAT_RET_BIT      4
`define STAT_BRAKE_BIT    5

// Packed position fields in limits and position registers
`define FIELD_LO_LSB      0
`define FIELD_HI_LSB      16

// Position and setpoint codes, 12-bit converter over 0 V to 5 V
`define POS_WIDTH         12
`define POS_MIN           12'h000
`define POS_MAX           12'hFFF
`define SPAN_LO_CODE      12'h19A
`define SPAN_HI_CODE      12'hE66
`define FOLLOW_DEADBAND   12'h004

// Timing
`define CLK_HZ            20000000
`define IDLE_TIME_S       15
`define PROG_HOLD_S       5
`define IDLE_CYCLES       (`IDLE_TIME_S * `CLK_HZ)
`define PROG_HOLD_CYCLES  (`PROG_HOLD_S * `CLK_HZ)

`endif

// [tb/actuator_motion_controller_properties.sv]
`timescale 1ns/1ns
module amc_checker
#(
  parameter [31:0] IDLE_CYCLES = 32'd50
)
(
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        extend_cmd,
  input wire        retract_cmd,
  input wire        prog_extend,
  input wire        prog_retract,
  input wire [11:0] position,
  input wire        drive_extend,
  input wire        drive_retract,
  input wire        brake,
  input wire        sleeping,
  input wire        end_min,
  input wire        end_max
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] idle_cnt;
  wire quiet = !(extend_cmd || retract_cmd || prog_extend || prog_retract);
  // Counts only cycles with quiet inputs, no drive and no sleep; any drive clears the count
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      idle_cnt <= 32'h0000_0000;
    else
      idle_cnt <= (quiet && !drive_extend && !drive_retract && !sleeping) ? idle_cnt + 1 : 0;
  chk_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  chk_both_stop: assert property (extend_cmd && retract_cmd |=>
    brake && !drive_extend && !drive_retract) else $error("both not braked");
  chk_ext_only: assert property (extend_cmd && !retract_cmd |=> !drive_retract)
    else $error("wrong direction");
  chk_ret_only: assert property (retract_cmd && !extend_cmd |=> !drive_extend)
    else $error("wrong direction");
  chk_brake_idle: assert property ($past(presetn) && !sleeping |->
    brake == !(drive_extend || drive_retract)) else $error("brake wrong");
  chk_sleep_quiet: assert property (sleeping |-> !brake && !drive_extend)
    else $error("asleep but active");
  chk_wake_up: assert property (sleeping && !quiet |=> !sleeping)
    else $error("no wake");
  chk_end_low: assert property (position == 12'h000 |=> end_min)
    else $error("end_min open");
  chk_end_high: assert property (position == 12'hFFF |=> end_max)
    else $error("end_max open");
  chk_idle_limit: assert property (idle_cnt <= IDLE_CYCLES + 3)
    else $error("no sleep");
  cover property ($rose(sleeping));
  cover property (extend_cmd && retract_cmd);
  cover property (drive_extend && !extend_cmd);
endmodule // amc_checker

bind actuator_motion_controller amc_checker #(.IDLE_CYCLES(IDLE_CYCLES)) chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .extend_cmd(extend_cmd), .retract_cmd(retract_cmd), .prog_extend(prog_extend),
  .prog_retract(prog_retract), .position(position), .drive_extend(drive_extend),
  .drive_retract(drive_retract), .brake(brake), .sleeping(sleeping),
  .end_min(end_min), .end_max(end_max));

// [tb/actuator_motion_controller_tb.sv]
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module actuator_motion_controller_tb;
  localparam [31:0] IDLE = 32'd50;
  localparam [31:0] HOLD = 32'd20;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rerr;
  logic [11:0] paddr = 0, setpoint = 0, position = 12'h600, sp;
  logic [31:0] pwdata = 0, rdat;
  logic        want_ext = 0, want_ret = 0, want_pe = 0, want_pr = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, extend_cmd, retract_cmd, prog_extend, prog_retract;
  wire         drive_extend, drive_retract, brake, sleeping, end_min, end_max;
  int          err_total = 0, cmp_count = 0, rl = 0, el = 4095;
  always #25 pclk = ~pclk;
  host_panel panel_u (.pclk(pclk), .presetn(presetn), .want_ext(want_ext),
    .want_ret(want_ret), .want_pe(want_pe), .want_pr(want_pr), .extend_cmd(extend_cmd),
    .retract_cmd(retract_cmd), .prog_extend(prog_extend), .prog_retract(prog_retract));
  actuator_motion_controller #(.IDLE_CYCLES(IDLE), .PROG_HOLD_CYCLES(HOLD)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extend_cmd(extend_cmd), .retract_cmd(retract_cmd), .prog_extend(prog_extend),
    .prog_retract(prog_retract), .setpoint(setpoint), .position(position),
    .drive_extend(drive_extend), .drive_retract(drive_retract), .brake(brake),
    .sleeping(sleeping), .end_min(end_min), .end_max(end_max));
  task give_verdict();
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      err_total++;
      give_verdict();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  function automatic int tgt(input int s);
    if (s <= 12'h19A) return rl;
    if (s >= 12'hE66) return el;
    return rl + (s - 12'h19A) * (el - rl) / (12'hE66 - 12'h19A);
  endfunction
  task automatic manual(input logic [11:0] p, input logic e, input logic r);
    logic de, dr;
    de = e && !r && p < el;
    dr = r && !e && p > rl;
    position <= p; want_ext <= e; want_ret <= r;
    cyc(3);
    `CHK(drive_extend, de)
    `CHK(drive_retract, dr)
    `CHK(brake, !(de || dr))
    `CHK(end_min, p == 12'h000)
    `CHK(end_max, p == 12'hFFF)
    want_ext <= 0; want_ret <= 0;
    cyc(3);
    `CHK(brake, 1'b1)
  endtask
  // Hold time fixed by the programming rule, plus margin for standstill
  task prog(input logic e, input logic r, input logic [11:0] s);
    setpoint <= s; want_pe <= e; want_pr <= r;
    cyc(HOLD + 10);
    want_pe <= 0; want_pr <= 0;
    cyc(2);
  endtask
  initial
  begin
    cyc(20000);
    err_total++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'h2881_23a1));
    cyc(5);
    presetn <= 1;
    apb(0, 12'h000, 0);
    `CHK(rdat, 32'h0000_0000)
    apb(0, 12'h008, 0);
    `CHK(rdat, 32'h0FFF_0000)
    apb(0, 12'h010, 0);
    `CHK({rerr, rdat}, 33'h1_0000_0000)
    $display("test registers done");
    manual(12'h000, 0, 1); manual(12'hFFF, 1, 0); manual(12'h600, 1, 0);
    manual(12'h600, 0, 1); manual(12'h600, 1, 1);
    $display("test manual done");
    cyc(IDLE + 5);
    `CHK(sleeping, 1'b1)
    want_ext <= 1;
    cyc(3);
    `CHK({sleeping, drive_extend}, 2'b01)
    want_ext <= 0;
    $display("test sleep done");
    // Limits go in first, retract below extend, before follower use
    position <= 12'h800; prog(1, 0, 12'h000); el = 12'h800;
    position <= 12'h400; prog(0, 1, 12'h000); rl = 12'h400;
    apb(0, 12'h008, 0);
    `CHK(rdat, 32'(el << 16 | rl))
    manual(12'h800, 1, 0); manual(12'h400, 0, 1); manual(12'h600, 0, 1);
    $display("test limits done");
    apb(1, 12'h000, 32'h0000_0001);
    for (int i = 0; i < 12; i++)
    begin
      sp = (i == 0) ? 12'hE66 : (i == 1) ? 12'h19A : 12'($urandom_range(4095));
      setpoint <= sp; position <= 12'h600;
      cyc(3);
      if (i < 2)
        `CHK(drive_extend, tgt(sp) > 12'h604)
      apb(0, 12'h00C, 0);
      `CHK(rdat[27:16], 12'(tgt(sp)))
    end
    // Settled follower sleeps, then a setpoint move must wake it
    setpoint <= 12'hE66; position <= 12'h800;
    cyc(IDLE + 8);
    `CHK(sleeping, 1'b1)
    setpoint <= 12'h19A;
    cyc(3);
    `CHK({sleeping, drive_retract}, 2'b01)
    $display("test follower done");
    apb(1, 12'h000, 0);
    // Setpoint inside the span must block programming
    position <= 12'h700; prog(1, 0, 12'h800);
    apb(0, 12'h008, 0);
    `CHK(rdat, 32'(el << 16 | rl))
    prog(1, 1, 12'h000); rl = 0; el = 4095;
    apb(0, 12'h008, 0);
    `CHK(rdat, 32'h0FFF_0000)
    $display("test clear done");
    give_verdict();
  end
endmodule // actuator_motion_controller_tb

// [tb/host_panel.sv]
`timescale 1ns/1ns
module host_panel
(
  input  wire  pclk,
  input  wire  presetn,
  input  wire  want_ext,
  input  wire  want_ret,
  input  wire  want_pe,
  input  wire  want_pr,
  output logic extend_cmd,
  output logic retract_cmd,
  output logic prog_extend,
  output logic prog_retract
);
  wire still = !want_ext && !want_ret;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {extend_cmd, retract_cmd, prog_extend, prog_retract} <= 4'h0;
    end
    else
    begin
      extend_cmd   <= want_ext;
      retract_cmd  <= want_ret;
      // Programming only with no move asked
      prog_extend  <= want_pe && still;
      prog_retract <= want_pr && still;
    end
  end
endmodule // host_panel
